// File: hw/eut_cfg.svh
/*
 what: constants for the enhanced up/down timer core (offsets, fields, codes, resets)
 assumes: included by bare name from the design modules and the bench
*/
`ifndef EUT_CFG_SVH
`define EUT_CFG_SVH
// apb byte offsets, one aligned word per register
`define EUT_OFF_CLK_PER 12'h000
`define EUT_OFF_CHAN_A 12'h004
`define EUT_OFF_CHAN_B 12'h008
`define EUT_OFF_CNT_LO 12'h00C
`define EUT_OFF_CNT_HI 12'h010
`define EUT_OFF_CMPA_LO 12'h014
`define EUT_OFF_CMPA_HI 12'h018
`define EUT_OFF_CMPB_LO 12'h01C
`define EUT_OFF_CMPB_HI 12'h020
`define EUT_OFF_STATUS 12'h024
// reset values
`define EUT_RST_BYTE 8'h00
`define EUT_RST_HI2 2'h0
// clock-period register fields
`define EUT_B_PAUSE 7
`define EUT_B_CKS_HI 6
`define EUT_B_CKS_LO 4
`define EUT_B_ON 3
`define EUT_B_PER_HI 2
`define EUT_B_PER_LO 0
// channel a register fields
`define EUT_B_MODE_HI 7
`define EUT_B_MODE_LO 6
`define EUT_B_PF_HI 5
`define EUT_B_PF_LO 4
`define EUT_B_OLVL 3
`define EUT_B_INV 2
`define EUT_B_DIR 1
`define EUT_B_CLRSEL 0
// channel b register: pwm alignment field
`define EUT_B_ALIGN_HI 1
`define EUT_B_ALIGN_LO 0
// clock select codes
`define EUT_CK_SYS4 3'h0
`define EUT_CK_SYS 3'h1
`define EUT_CK_H16 3'h2
`define EUT_CK_H64 3'h3
`define EUT_CK_SUB 3'h4
`define EUT_CK_RSV 3'h5
`define EUT_CK_PINR 3'h6
`define EUT_CK_PINF 3'h7
// prescaler terminal counts and counter geometry
`define EUT_DIV4_LAST 6'h03
`define EUT_DIV16_LAST 6'h0F
`define EUT_DIV64_LAST 6'h3F
`define EUT_CNT_MAX 10'h3FF
`define EUT_CNT_ZERO 10'h000
`define EUT_PER_ZERO 3'h0
`define EUT_CNT_TOP_HI 9
`define EUT_CNT_TOP_LO 7
// pin-function codes
`define EUT_PF_00 2'h0
`define EUT_PF_01 2'h1
`define EUT_PF_10 2'h2
`define EUT_PF_11 2'h3
`endif

// File: hw/eut_pkg.sv
/*
 what: shared types of the enhanced up/down timer core
 assumes: nothing is imported; users write eut_pkg::name
*/
package eut_pkg;
  // channel a operating modes, in register code order
  typedef enum logic [1:0] {
    EUT_MODE_CMP,
    EUT_MODE_CAP,
    EUT_MODE_PWM,
    EUT_MODE_TMR
  } eut_mode_t;
  // pwm alignment choices, in register code order
  typedef enum logic [1:0] {
    EUT_AL_EDGE,
    EUT_AL_CUP,
    EUT_AL_CDN,
    EUT_AL_CBOTH
  } eut_align_t;
endpackage

// File: hw/eut_tick_gen.sv
/*
 what: count-enable generator, turns the clock select code into one-cycle ticks
 assumes: ref_clk is the system clock and also stands for the high and sub clocks;
 the external pin is synchronous to ref_clk
*/
`timescale 1ns/1ps
`default_nettype none
`include "eut_cfg.svh"
module eut_tick_gen (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // control
  input wire logic run,
  input wire logic [2:0] clk_sel,
  // external count clock pin
  input wire logic external_count_clock_pin,
  // tick out
  output logic tick
);
  logic [5:0] pre;
  logic pin_q;
  wire pin_rise = external_count_clock_pin & ~pin_q;
  wire pin_fall = ~external_count_clock_pin & pin_q;
  // prescaler runs freely while the timer is on, so its phase restarts at switch-on
  always_ff @(posedge ref_clk)
  begin
    if (srst || !run)
      pre <= 6'h00;
    else
      pre <= pre + 6'h01;
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      pin_q <= 1'b0;
    else
      pin_q <= external_count_clock_pin;
  end
  // sub clock has no source of its own here, so it follows the system clock
  always_comb
  begin
    unique case (clk_sel)
      `EUT_CK_SYS4: tick = run && (pre[1:0] == 2'(`EUT_DIV4_LAST));
      `EUT_CK_SYS: tick = run;
      `EUT_CK_H16: tick = run && (pre[3:0] == 4'(`EUT_DIV16_LAST));
      `EUT_CK_H64: tick = run && (pre == `EUT_DIV64_LAST);
      `EUT_CK_SUB: tick = run;
      `EUT_CK_RSV: tick = 1'b0;
      `EUT_CK_PINR: tick = run && pin_rise;
      `EUT_CK_PINF: tick = run && pin_fall;
    endcase
  end
endmodule // eut_tick_gen
`default_nettype wire

// File: hw/eut_core.sv
/*
 what: ten-bit enhanced up/down timer core with apb registers, comparators a, b, p,
 capture and channel a waveform output
 assumes: apb master per the protocol, zero wait states; pins synchronous to ref_clk
*/
// Local design decisions: the placing of the registers and the APB slave port.
// Function
// (R01) ten-bit up/down counter, selectable clock
// (R02) period compares top three bits; a,b ten
// (R03) software only clears counter on switch-on
// (R04) overflow or selected match clears, flags event
// (R05) pause holds count, resumes from it
// (R06) clock select codes, 101 stops counting
// (R07) switch-off stops counter, keeps value
// (R08) switch-on restores initial output level
// (R09) period code N gives N times 128
// (R10) clear select picks period or a
// (R11) period zero lets counter overflow
// (R12) channel a mode field codes
// (R13) software switches off before mode change
// (R14) timer mode leaves output pin undriven
// (R15) compare match pin action codes
// (R16) same level as initial gives no change
// (R17) pwm pin function codes
// (R18) capture edge select codes
// (R19) software changes pwm function only off
// (R20) output level: initial or active level
// (R21) invert bit inverts output pin
// (R22) direction flag reads count direction
// (R23) pwm alignment select codes
// (R24) clear select ignored in pwm, capture
`timescale 1ns/1ps
`default_nettype none
`include "eut_cfg.svh"
module eut_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external pins
  input wire logic external_count_clock_pin,
  input wire logic chan_a_capture_pin,
  output logic chan_a_output_pin,
  output logic chan_a_output_oe,
  // events
  output logic match_a_event,
  output logic match_b_event,
  output logic match_p_event,
  output logic capture_event
);
  // register state
  logic [7:0] ctrl_clock_period;
  logic [7:0] ctrl_chan_a;
  logic [7:0] ctrl_chan_b;
  logic [9:0] compare_a_value;
  logic [9:0] compare_b_value;
  logic [9:0] count;
  logic count_direction_flag;
  logic on_q;
  logic cap_q;
  logic wave;
  logic [3:0] ev_sticky;
  logic tick;

  // field decode
  wire count_pause = ctrl_clock_period[`EUT_B_PAUSE];
  wire timer_on = ctrl_clock_period[`EUT_B_ON];
  wire [2:0] count_clock_select = ctrl_clock_period[`EUT_B_CKS_HI:`EUT_B_CKS_LO];
  wire [2:0] period_field = ctrl_clock_period[`EUT_B_PER_HI:`EUT_B_PER_LO];
  wire eut_pkg::eut_mode_t chan_a_mode =
    eut_pkg::eut_mode_t'(ctrl_chan_a[`EUT_B_MODE_HI:`EUT_B_MODE_LO]); // R12
  wire [1:0] chan_a_pin_function = ctrl_chan_a[`EUT_B_PF_HI:`EUT_B_PF_LO];
  wire chan_a_output_level = ctrl_chan_a[`EUT_B_OLVL];
  wire chan_a_invert = ctrl_chan_a[`EUT_B_INV];
  wire clear_source_select = ctrl_chan_a[`EUT_B_CLRSEL];
  wire eut_pkg::eut_align_t pwm_align_select =
    eut_pkg::eut_align_t'(ctrl_chan_b[`EUT_B_ALIGN_HI:`EUT_B_ALIGN_LO]);

  // mode decode
  wire mode_cmp = (chan_a_mode == eut_pkg::EUT_MODE_CMP);
  wire mode_cap = (chan_a_mode == eut_pkg::EUT_MODE_CAP);
  wire mode_pwm = (chan_a_mode == eut_pkg::EUT_MODE_PWM);
  wire mode_tmr = (chan_a_mode == eut_pkg::EUT_MODE_TMR);
  wire single_pulse = mode_pwm && (chan_a_pin_function == `EUT_PF_11);
  wire centre = mode_pwm && (pwm_align_select != eut_pkg::EUT_AL_EDGE);

  // apb decode, zero wait states
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction
  wire hit_cp = hit(paddr, `EUT_OFF_CLK_PER);
  wire hit_ca = hit(paddr, `EUT_OFF_CHAN_A);
  wire hit_cb = hit(paddr, `EUT_OFF_CHAN_B);
  wire hit_dl = hit(paddr, `EUT_OFF_CNT_LO);
  wire hit_dh = hit(paddr, `EUT_OFF_CNT_HI);
  wire hit_al = hit(paddr, `EUT_OFF_CMPA_LO);
  wire hit_ah = hit(paddr, `EUT_OFF_CMPA_HI);
  wire hit_bl = hit(paddr, `EUT_OFF_CMPB_LO);
  wire hit_bh = hit(paddr, `EUT_OFF_CMPB_HI);
  wire hit_st = hit(paddr, `EUT_OFF_STATUS);
  wire mapped = hit_cp | hit_ca | hit_cb | hit_dl | hit_dh | hit_al | hit_ah
    | hit_bl | hit_bh | hit_st;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // comparators: p sees the top three bits of the next count, a and b the whole count
  wire [9:0] count_inc = count + 10'h001; // one step ahead, so code n spans n times 128 ticks
  wire [2:0] count_top = count_inc[`EUT_CNT_TOP_HI:`EUT_CNT_TOP_LO];
  wire per_zero = (period_field == `EUT_PER_ZERO);
  wire eq_a = (count == compare_a_value); // R02
  wire eq_b = (count == compare_b_value); // R02
  wire eq_p = !per_zero && (count_top == period_field)
    && (count_inc[`EUT_CNT_TOP_LO - 1:0] == 7'h00); // R02 R09
  wire at_max = (count == `EUT_CNT_MAX);

  // count step qualification
  wire on_rise = timer_on && !on_q;
  wire step = tick && !count_pause && !on_rise; // R05; a stale count never matches at switch-on
  // a and b matches are taken at the step made from the compare value, p at the step that would reach it
  wire hit_a = step && eq_a;
  wire hit_b = step && eq_b;
  wire hit_p = step && eq_p;
  wire hit_ovf = step && at_max && !count_direction_flag;

  // clear source: period (or overflow when period is zero) or compare a
  wire use_clr_a = clear_source_select && (mode_cmp || mode_tmr); // R10 R24
  wire end_up_p = per_zero ? at_max : eq_p; // R11
  // pwm top: edge mode wraps, centre mode turns round
  wire at_top = use_clr_a ? eq_a : end_up_p;
  wire at_bottom = (count == `EUT_CNT_ZERO);
  wire wrap = step && at_top && !count_direction_flag && !centre; // R04 R10

  // single pulse ends on compare a and turns the timer off
  wire sp_end = single_pulse && hit_a;
  // capture edge detection on the capture pin
  wire cap_rise = chan_a_capture_pin && !cap_q;
  wire cap_fall = !chan_a_capture_pin && cap_q;
  wire cap_edge = (chan_a_pin_function == `EUT_PF_00) ? cap_rise :
                  (chan_a_pin_function == `EUT_PF_01) ? cap_fall :
                  (chan_a_pin_function == `EUT_PF_10) ? (cap_rise | cap_fall) :
                  1'b0; // R18
  wire cap_take = mode_cap && timer_on && cap_edge;

  // pwm match qualification by alignment
  wire a_up_ok = (pwm_align_select != eut_pkg::EUT_AL_CDN);
  wire a_dn_ok = (pwm_align_select != eut_pkg::EUT_AL_CUP);
  wire pwm_a_hit = hit_a && (!centre || (count_direction_flag ? a_dn_ok : a_up_ok)); // R23

  // tick generator
  eut_tick_gen u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(timer_on),
    .clk_sel(count_clock_select), // R06
    .external_count_clock_pin(external_count_clock_pin),
    .tick(tick)
  );

  // next count value
  logic [9:0] next_count;
  logic next_dir;
  always_comb
  begin
    next_count = count;
    next_dir = count_direction_flag;
    if (on_rise)
    begin
      next_count = `EUT_CNT_ZERO; // R03
      next_dir = 1'b0;
    end
    else if (step && !sp_end) // R07
    begin
      if (centre && !count_direction_flag && at_top)
      begin
        next_dir = 1'b1;
        next_count = count - 10'h001;
      end
      else if (centre && count_direction_flag && at_bottom)
      begin
        next_dir = 1'b0;
        next_count = count + 10'h001;
      end
      else if (wrap)
        next_count = `EUT_CNT_ZERO; // R04
      else if (count_direction_flag)
        next_count = count - 10'h001; // R01
      else
        next_count = count + 10'h001; // R01
    end
  end

  // counter and direction; held when off, paused or on reserved clock
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      count <= `EUT_CNT_ZERO;
      count_direction_flag <= 1'b0;
    end
    else
    begin
      count <= next_count;
      count_direction_flag <= next_dir; // R22
    end
  end

  // register writes; a capture wins over a software write of compare a
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctrl_clock_period <= `EUT_RST_BYTE;
      ctrl_chan_a <= `EUT_RST_BYTE;
      ctrl_chan_b <= `EUT_RST_BYTE;
      compare_a_value <= {`EUT_RST_HI2, `EUT_RST_BYTE};
      compare_b_value <= {`EUT_RST_HI2, `EUT_RST_BYTE};
    end
    else
    begin
      if (sp_end)
        ctrl_clock_period[`EUT_B_ON] <= 1'b0;
      else if (wr && hit_cp)
        ctrl_clock_period <= pwdata[7:0];
      if (wr && hit_ca)
        ctrl_chan_a <= {pwdata[7:2], ctrl_chan_a[`EUT_B_DIR], pwdata[0]};
      if (wr && hit_cb)
        ctrl_chan_b <= pwdata[7:0];
      if (cap_take)
        compare_a_value <= count;
      else if (wr && hit_al)
        compare_a_value[7:0] <= pwdata[7:0];
      else if (wr && hit_ah)
        compare_a_value[9:8] <= pwdata[1:0];
      if (wr && hit_bl)
        compare_b_value[7:0] <= pwdata[7:0];
      else if (wr && hit_bh)
        compare_b_value[9:8] <= pwdata[1:0];
    end
  end

  // channel a waveform before polarity
  logic next_wave;
  wire cmp_lvl = (chan_a_pin_function == `EUT_PF_10);
  always_comb
  begin
    next_wave = wave;
    if (mode_cmp)
    begin
      if (on_rise)
        next_wave = chan_a_output_level; // R08 R20
      else if (hit_a && chan_a_pin_function == `EUT_PF_11)
        next_wave = ~wave; // R15
      else if (hit_a && chan_a_pin_function != `EUT_PF_00
               && cmp_lvl != chan_a_output_level)
        next_wave = cmp_lvl; // R15 R16
    end
    else if (mode_pwm)
    begin
      if (chan_a_pin_function == `EUT_PF_00)
        next_wave = 1'b0; // R17
      else if (chan_a_pin_function == `EUT_PF_01)
        next_wave = 1'b1; // R17
      else if (single_pulse)
        next_wave = on_rise ? 1'b1 : (sp_end || !timer_on) ? 1'b0 : wave; // R17
      else if (on_rise || (wrap && !centre))
        next_wave = 1'b1;
      else if (pwm_a_hit)
        next_wave = 1'b0;
    end
  end

  // pin level: active level and polarity applied after the waveform
  wire act_lvl = mode_pwm ? (wave ~^ chan_a_output_level) : wave; // R20
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wave <= 1'b0;
      on_q <= 1'b0;
      cap_q <= 1'b0;
      chan_a_output_pin <= 1'b0;
      chan_a_output_oe <= 1'b0;
    end
    else
    begin
      wave <= next_wave;
      on_q <= timer_on;
      cap_q <= chan_a_capture_pin;
      chan_a_output_pin <= act_lvl ^ chan_a_invert; // R21
      chan_a_output_oe <= mode_cmp || mode_pwm; // R14
    end
  end

  // event pulses; p events exist only while compare a is not the clear source
  wire p_evt = hit_p && !use_clr_a || (per_zero && hit_ovf && !use_clr_a); // R04
  wire [3:0] ev_now = {cap_take, p_evt, hit_b, hit_a || (use_clr_a && hit_ovf)};
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      match_a_event <= 1'b0;
      match_b_event <= 1'b0;
      match_p_event <= 1'b0;
      capture_event <= 1'b0;
    end
    else
    begin
      match_a_event <= ev_now[0];
      match_b_event <= ev_now[1];
      match_p_event <= ev_now[2];
      capture_event <= ev_now[3];
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  wire [3:0] clr_mask = (wr && hit_st) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      ev_sticky <= 4'h0;
    else
      ev_sticky <= (ev_sticky & ~clr_mask) | ev_now;
  end

  // read mux
  wire [31:0] rd_val =
    hit_cp ? {24'h000000, ctrl_clock_period} :
    hit_ca ? {24'h000000, ctrl_chan_a[7:2], count_direction_flag, ctrl_chan_a[0]} :
    hit_cb ? {24'h000000, ctrl_chan_b} :
    hit_dl ? {24'h000000, count[7:0]} :
    hit_dh ? {30'h0, count[9:8]} :
    hit_al ? {24'h000000, compare_a_value[7:0]} :
    hit_ah ? {30'h0, compare_a_value[9:8]} :
    hit_bl ? {24'h000000, compare_b_value[7:0]} :
    hit_bh ? {30'h0, compare_b_value[9:8]} :
    hit_st ? {28'h0000000, ev_sticky} : 32'h00000000;
  assign prdata = (acc && !pwrite) ? rd_val : 32'h00000000;

  // checks
  on_clears_a: assert property (@(posedge ref_clk) disable iff (srst) // R03
    $rose(timer_on) |=> (count == `EUT_CNT_ZERO))
    else $error("counter not cleared on switch-on");
  off_holds_a: assert property (@(posedge ref_clk) disable iff (srst) // R07
    !timer_on && !$rose(timer_on) |=> $stable(count))
    else $error("counter moved while off");
  pause_hold_a: assert property (@(posedge ref_clk) disable iff (srst) // R05
    count_pause && on_q && timer_on |=> count == $past(count))
    else $error("counter moved while paused");
  rsv_stop_a: assert property (@(posedge ref_clk) disable iff (srst) // R06
    count_clock_select == `EUT_CK_RSV && on_q && timer_on |=> $stable(count))
    else $error("reserved clock still counts");
  tmr_pin_a: assert property (@(posedge ref_clk) disable iff (srst) // R14
    mode_tmr |=> !chan_a_output_oe)
    else $error("pin driven in timer mode");
  init_lvl_a: assert property (@(posedge ref_clk) disable iff (srst) // R08
    mode_cmp && on_rise ##1 mode_cmp && !wr
      |=> chan_a_output_pin == (chan_a_output_level ^ chan_a_invert))
    else $error("initial level not restored");
  per_clear_a: assert property (@(posedge ref_clk) disable iff (srst) // R04
    wrap && !on_rise && !sp_end |=> count == `EUT_CNT_ZERO)
    else $error("clear on match missed");
  cap_load_a: assert property (@(posedge ref_clk) disable iff (srst) // R18
    cap_take |=> compare_a_value == $past(count))
    else $error("capture did not load compare a");
  cov_cmp_c: cover property (@(posedge ref_clk) mode_cmp && hit_a);
  cov_cap_c: cover property (@(posedge ref_clk) cap_take);
  cov_pwm_c: cover property (@(posedge ref_clk) mode_pwm && wrap);
  cov_sp_c: cover property (@(posedge ref_clk) sp_end);
endmodule // eut_core
`default_nettype wire

// File: dv/eut_pin_model.sv
/*
 what: pin-side model of the timer core: external count clock source and capture input driver
 assumes: ref_clk is the bench clock; pins change only just after rising edges
*/
`timescale 1ns/1ps
`default_nettype none
module eut_pin_model (
  // clock
  input wire logic ref_clk,
  // requests from the bench
  input wire logic tck_run,
  input wire logic cap_pulse,
  // pins
  output logic external_count_clock_pin,
  output logic chan_a_capture_pin
);
  logic [2:0] tck_div;
  logic [3:0] cap_len;
  initial
  begin
    tck_div = 3'h0;
    cap_len = 4'h0;
    external_count_clock_pin = 1'b0;
    chan_a_capture_pin = 1'b0;
  end
  // count clock of eight ref_clk cycles; it stands low while not requested
  always @(posedge ref_clk)
  begin
    tck_div <= tck_run ? tck_div + 3'h1 : 3'h0;
    external_count_clock_pin <= tck_run & tck_div[2];
  end
  // one high pulse of about ten cycles per request, so both edges are seen
  always @(posedge ref_clk)
  begin
    if (cap_pulse)
      cap_len <= 4'hA;
    else if (cap_len != 4'h0)
      cap_len <= cap_len - 4'h1;
    chan_a_capture_pin <= (cap_len > 4'h1) | cap_pulse;
  end
endmodule // eut_pin_model
`default_nettype wire

// File: dv/enhanced_updown_timer_core_test.sv
/*
 what: self-checking bench of the timer core: apb master, pin model, event counters
 assumes: eut_core answers apb with zero or more wait states; events are one-cycle pulses
*/
`timescale 1ns/1ps
`default_nettype none
`include "eut_cfg.svh"
module enhanced_updown_timer_core_test;
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic tck, cap_pin, out_pin, out_oe, ev_a, ev_b, ev_p, ev_cap, tck_run, cap_pulse;
  logic [7:0] lfsr;
  logic [33:0] e_head;
  logic [33:0] expq[$];
  int fails, n_checks, n, na, nb, c;
  int cnt[4];
  int spc[8] = '{512, 128, 2048, 8192, 128, 0, 1024, 1024};
  int ce[4] = '{1, 1, 2, 0};
  logic [7:0] lv[8] = '{8'h01, 8'h0B, 8'h0D, 8'h89, 8'h9B, 8'h91, 8'h85, 8'hC8};
  logic [8:0] pa[4] = '{9'h129, 9'h019, 9'h121, 9'h109};

  eut_core eut_core_i (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_clock_pin(tck), .chan_a_capture_pin(cap_pin),
    .chan_a_output_pin(out_pin), .chan_a_output_oe(out_oe), .match_a_event(ev_a),
    .match_b_event(ev_b), .match_p_event(ev_p), .capture_event(ev_cap));
  eut_pin_model eut_pin_model_i (.ref_clk(ref_clk), .tck_run(tck_run), .cap_pulse(cap_pulse),
    .external_count_clock_pin(tck), .chan_a_capture_pin(cap_pin));

  always #10 ref_clk = ~ref_clk;

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one apb transfer; its expected answer is noted before the setup cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] exp, input logic err);
    int t;
    expq.push_back({wr, err, exp});
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge ref_clk);
      t++;
    end
    while (pready !== 1'b1 && t < 100);
    if (pready !== 1'b1)
      fails++; // a slave that never answers counts as a mismatch
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic w(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, exp, 1'b0);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // waits, bounded, for the next pulse of event k; n is the wait in cycles
  task automatic wait_evt(input int k, output int n);
    int c0;
    c0 = cnt[k];
    n = 0;
    while (cnt[k] == c0 && n < 20000)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic gap(input int k, output int n);
    wait_evt(k, n);
    wait_evt(k, n);
  endtask

  // answer watcher: compares each completed transfer with the oldest note
  always @(posedge ref_clk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      e_head = expq.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, e_head[32]});
      if (!e_head[33])
        check("prdata", prdata, e_head[31:0]);
    end

  // events counted at the falling edge, read by the tasks at the rising edge
  always @(negedge ref_clk)
  begin
    if (ev_a === 1'b1) cnt[0]++;
    if (ev_p === 1'b1) cnt[1]++;
    if (ev_b === 1'b1) cnt[2]++;
    if (ev_cap === 1'b1) cnt[3]++;
  end

  // hang guard, longer than the whole sequence
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end

  initial
  begin
    ref_clk = 1'b0;
    srst = 1'b1;
    {psel, penable, pwrite, tck_run, cap_pulse} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    lfsr = 8'h19;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    // reset values, read-only direction flag, unmapped place
    rd(`EUT_OFF_CLK_PER, 32'h0);
    rd(`EUT_OFF_CHAN_B, 32'h0);
    w(`EUT_OFF_CHAN_A, 32'h02);
    rd(`EUT_OFF_CHAN_A, 32'h0);
    apb(1'b0, 12'h028, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h0FC, 32'h5A, 32'h0, 1'b1);
    // reserved clock: switch-on clears, nothing counts, count writes are lost
    w(`EUT_OFF_CLK_PER, 32'h58);
    w(`EUT_OFF_CNT_LO, 32'h55);
    cyc(50);
    rd(`EUT_OFF_CNT_LO, 32'h0);
    rd(`EUT_OFF_CNT_HI, 32'h0);
    // paused from switch-on, then released into a full overflow
    w(`EUT_OFF_CLK_PER, 32'h0);
    w(`EUT_OFF_CLK_PER, 32'h98);
    cyc(50);
    rd(`EUT_OFF_CNT_LO, 32'h0);
    w(`EUT_OFF_CLK_PER, 32'h18);
    gap(1, n);
    check("overflow gap", n, 1024);
    w(`EUT_OFF_CLK_PER, 32'h10);
    c = cnt[1];
    cyc(1100);
    check("events when off", cnt[1] - c, 0);
    // every clock code with period code 1, external pin period eight cycles
    for (int k = 0; k < 8; k++)
    begin
      tck_run <= (k >= 6);
      w(`EUT_OFF_CLK_PER, (k << 4) | 1);
      w(`EUT_OFF_CLK_PER, (k << 4) | 9);
      c = cnt[1];
      if (k == 5)
      begin
        cyc(1200);
        check("reserved clock", cnt[1] - c, 0);
      end
      else
      begin
        gap(1, n);
        check("clock code gap", n, spc[k]);
      end
    end
    tck_run <= 1'b0;
    for (int p = 2; p < 8; p++)
    begin
      w(`EUT_OFF_CLK_PER, 32'h10);
      w(`EUT_OFF_CLK_PER, 32'h18 | p);
      gap(1, n);
      check("period gap", n, p * 128);
    end
    // pin level and enable per mode, function, level and invert; off before changes
    foreach (lv[i])
    begin
      w(`EUT_OFF_CLK_PER, 32'h10);
      w(`EUT_OFF_CHAN_A, {lv[i][7:2], 2'b00});
      w(`EUT_OFF_CLK_PER, 32'h18);
      cyc(4);
      check("pin enable", {31'h0, out_oe}, {31'h0, lv[i][0]});
      if (lv[i][0])
        check("pin level", {31'h0, out_pin}, {31'h0, lv[i][1]});
    end
    // compare a clears and toggles; b matches but never clears
    w(`EUT_OFF_CLK_PER, 32'h10);
    w(`EUT_OFF_CMPA_LO, 32'd40);
    w(`EUT_OFF_CMPA_HI, 32'h0);
    lfsr = lfsr_next(lfsr);
    w(`EUT_OFF_CMPB_HI, {24'h0, lfsr});
    rd(`EUT_OFF_CMPB_HI, {30'h0, lfsr[1:0]});
    w(`EUT_OFF_CMPB_HI, 32'h0);
    lfsr = lfsr_next(lfsr);
    w(`EUT_OFF_CMPB_LO, {27'h0, lfsr[4:0]});
    rd(`EUT_OFF_CMPB_LO, {27'h0, lfsr[4:0]});
    w(`EUT_OFF_CHAN_A, 32'h31);
    w(`EUT_OFF_CLK_PER, 32'h19);
    c = cnt[1];
    for (int i = 1; i < 5; i++)
    begin
      wait_evt(0, n);
      cyc(3);
      check("toggled pin", {31'h0, out_pin}, {31'h0, i[0]});
    end
    gap(0, na);
    gap(2, nb);
    check("b match gap", nb, na);
    check("p events", cnt[1] - c, 0);
    // other pin actions, from their initial level
    foreach (pa[i])
    begin
      w(`EUT_OFF_CLK_PER, 32'h10);
      w(`EUT_OFF_CHAN_A, pa[i][7:0]);
      w(`EUT_OFF_CLK_PER, 32'h19);
      wait_evt(0, n);
      cyc(3);
      check("match pin", {31'h0, out_pin}, {31'h0, pa[i][8]});
    end
    // capture edges, with clear select set but ignored
    for (int k = 0; k < 4; k++)
    begin
      w(`EUT_OFF_CLK_PER, 32'h10);
      w(`EUT_OFF_CHAN_A, 32'h41 | (k << 4));
      w(`EUT_OFF_CLK_PER, 32'h18);
      c = cnt[3];
      cap_pulse <= 1'b1;
      @(posedge ref_clk);
      cap_pulse <= 1'b0;
      cyc(30);
      check("captures", cnt[3] - c, ce[k]);
    end
    gap(1, n);
    check("capture overflow gap", n, 1024);
    // single pulse: starts at switch-on, compare a ends it and switches the timer off
    w(`EUT_OFF_CLK_PER, 32'h10);
    w(`EUT_OFF_CHAN_A, 32'hB8);
    w(`EUT_OFF_CMPA_LO, 32'h28);
    w(`EUT_OFF_CLK_PER, 32'h18);
    cyc(3);
    check("pulse start", {31'h0, out_pin}, 32'h1);
    wait_evt(0, n);
    cyc(3);
    check("pulse end", {31'h0, out_pin}, 32'h0);
    rd(`EUT_OFF_CLK_PER, 32'h10);
    // sticky status holds every event kind seen so far; write one clears
    rd(`EUT_OFF_STATUS, 32'hF);
    w(`EUT_OFF_STATUS, 32'hF);
    rd(`EUT_OFF_STATUS, 32'h0);
    // edge-aligned pwm, active high: compare a ends the active phase, the period restarts it
    w(`EUT_OFF_CHAN_A, 32'hA8);
    w(`EUT_OFF_CLK_PER, 32'h19);
    wait_evt(0, n);
    cyc(3);
    check("pwm low", {31'h0, out_pin}, 32'h0);
    wait_evt(1, n);
    cyc(3);
    check("pwm high", {31'h0, out_pin}, 32'h1);
    // centre aligned: just after the period top the counter runs down
    w(`EUT_OFF_CLK_PER, 32'h11);
    w(`EUT_OFF_CHAN_B, 32'h03);
    w(`EUT_OFF_CLK_PER, 32'h19);
    wait_evt(1, n);
    rd(`EUT_OFF_CHAN_A, 32'hAA);
    end_of_test();
  end
endmodule // enhanced_updown_timer_core_test
`default_nettype wire
